// ---- rtl/mbs_scan_port.sv ----
/*
   Boundary-scan test logic of the memory device: pin synchronisers,
   scan-clock edge finder, scan-event queue and the 67-position chain.
   Assumes all scan pins are asynchronous to clk and that the scan clock
   pulse and pulse gap are each at least two clk periods long.
*/
// Behaviour
// R1 - With the shift select low a scan clock edge loads the pads into the chain, with it high the chain shifts one place.
// R2 - Every scan input is taken at the scan clock rising edge and the clock is never assumed to run continuously; pads are read when the capture applies.
// R3 - The tester may give the scan clock as one pulse or a burst, never as a free-running clock.
// R4 - Scan mode is on while the test mode select is high and off while it is low.
// R5 - Scan data goes to the serial output only once the drive enable has been registered high.
// R6 - In scan mode the mirror selection is ignored so no signal is remapped.
// R7 - The chain has 67 positions and shifting past the last one yields zeros from its grounded far input.
// R8 - Positions 20, 56 and 57 always capture and read back as zero.
// R9 - While test mode select is high no memory command of any kind executes.
// R10 - The tester finishes power-up and initialisation before relying on scan.
// R11 - In scan mode the address and control termination is nominal and data termination is off.
// R12 - With two devices back to back the tester enables scan on both and drives only one drive enable.
// R13 - After scan use the device is power cycled and reinitialised before normal operation.
// R14 - With the drive enable low the serial output pin is left undriven.

// Synchronous FIFO, flip-flop storage
module mbs_fifo
   import mbs_pkg::*;
#(
   parameter int WIDTH = EVQ_WIDTH,
   parameter int DEPTH = EVQ_DEPTH
)(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wrPtr;
      logic [AW-1:0]               rdPtr;
      logic [AW:0]                 count;
   } mbs_fifo_state_t;

   mbs_fifo_state_t st_q;
   mbs_fifo_state_t st_d;
   logic            doPush;
   logic            doPop;

   // Honest flags straight from the occupancy count
   assign inReady  = (st_q.count != (AW+1)'(DEPTH));
   assign outValid = (st_q.count != '0);
   assign outData  = st_q.mem[st_q.rdPtr];
   assign doPush   = inValid && inReady;
   assign doPop    = outValid && outReady;

   // Next state
   always_comb
   begin
      st_d = st_q;
      if (doPush)
      begin
         st_d.mem[st_q.wrPtr] = inData;
         st_d.wrPtr = (st_q.wrPtr == AW'(DEPTH-1)) ? '0 : st_q.wrPtr + AW'(1);
      end
      if (doPop)
      begin
         st_d.rdPtr = (st_q.rdPtr == AW'(DEPTH-1)) ? '0 : st_q.rdPtr + AW'(1);
      end
      st_d.count = st_q.count + (AW+1)'(doPush) - (AW+1)'(doPop);
      // Flush drops queued events when scan mode ends
      if (flush)
      begin
         st_d.wrPtr = '0;
         st_d.rdPtr = '0;
         st_d.count = '0;
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end
endmodule // mbs_fifo

// Scan port top
module mbs_scan_port
   import mbs_pkg::*;
#(
   parameter int LEN = CHAIN_LEN
)(
   input  wire logic           clk,
   input  wire logic           rst,
   input  wire logic           testModeSelect,
   input  wire logic           scanClk,
   input  wire logic           captureOrShiftSelect,
   input  wire logic           resultDriveEnable,
   input  wire logic           mirrorSelect,
   input  wire logic           memCmdValid,
   input  wire logic [LEN-1:0] padIn,
   output logic                serialResultOut,
   output logic                serialResultOe,
   output logic                mirrorActive,
   output logic                memCmdExecute,
   output logic                caTermNominal,
   output logic                dqTermDisable,
   output logic                scanEventReady
);
   typedef struct packed {
      logic [1:0]     senSync;       // [0] first stage, [1] usable
      logic [1:0]     sshSync;
      logic [1:0]     soeSync;
      logic [1:0]     mfSync;
      logic [1:0]     cmdSync;
      logic [2:0]     sckSync;       // [2] is last cycle's usable level
      logic [LEN-1:0] padSync0;
      logic [LEN-1:0] padSync1;
      logic [LEN-1:0] chain;
      logic           driveEn;
      logic           op;
      mbs_state_t     state;
   } mbs_port_state_t;

   mbs_port_state_t st_q;
   mbs_port_state_t st_d;
   logic            scanMode;
   logic            sckRise;
   logic            evValid;
   logic            evReady;
   logic            evData;
   logic            evPush;

   assign scanMode = st_q.senSync[1];                          // R4
   // Edge found on synchronised levels only; a lone pulse is enough
   assign sckRise  = st_q.sckSync[1] && !st_q.sckSync[2];      // R2
   assign evPush   = scanMode && sckRise;
   assign evReady  = (st_q.state == MBS_IDLE);

   // Queue of scan clock events, shift select taken at the edge
   mbs_fifo #(
      .WIDTH (EVQ_WIDTH),
      .DEPTH (EVQ_DEPTH)
   ) u_evq (
      .clk      (clk),
      .rst      (rst),
      .flush    (!scanMode),
      .inValid  (evPush),
      .inReady  (scanEventReady),
      .inData   (st_q.sshSync[1]),                             // R2
      .outValid (evValid),
      .outReady (evReady),
      .outData  (evData)
   );

   // Next state: synchronisers, drive enable, chain engine
   always_comb
   begin
      st_d = st_q;
      st_d.senSync  = {st_q.senSync[0], testModeSelect};
      st_d.sshSync  = {st_q.sshSync[0], captureOrShiftSelect};
      st_d.soeSync  = {st_q.soeSync[0], resultDriveEnable};
      st_d.mfSync   = {st_q.mfSync[0], mirrorSelect};
      st_d.cmdSync  = {st_q.cmdSync[0], memCmdValid};
      st_d.sckSync  = {st_q.sckSync[1:0], scanClk};
      st_d.padSync0 = padIn;
      st_d.padSync1 = st_q.padSync0;
      // Drive enable is registered on the scan clock edge
      if (!scanMode)
      begin
         st_d.driveEn = 1'b0;
      end
      else if (sckRise)
      begin
         st_d.driveEn = st_q.soeSync[1];                       // R5
      end
      case (st_q.state)
         MBS_IDLE:
         begin
            if (evValid)
            begin
               st_d.op    = evData;
               st_d.state = MBS_APPLY;
            end
         end
         MBS_APPLY:
         begin
            if (st_q.op)
            begin
               // Far end tied low, so zeros follow the last position
               st_d.chain = {1'b0, st_q.chain[LEN-1:1]};       // R1 R7
            end
            else
            begin
               st_d.chain = st_q.padSync1 & LEN'(CAPTURE_MASK); // R1 R8
            end
            st_d.state = MBS_IDLE;
         end
         default:
         begin
            st_d.state = MBS_IDLE;
         end
      endcase
      if (!scanMode)
      begin
         st_d.state = MBS_IDLE;
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q         <= '0;
         st_q.chain   <= LEN'(CHAIN_RESET);
         st_q.state   <= MBS_IDLE;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Pin and side-band outputs
   assign serialResultOe  = scanMode && st_q.driveEn;                  // R5 R14
   assign serialResultOut = serialResultOe && st_q.chain[0];           // R14
   assign mirrorActive    = st_q.mfSync[1] && !scanMode;               // R6
   assign memCmdExecute   = st_q.cmdSync[1] && !scanMode;              // R9
   assign caTermNominal   = scanMode;                                  // R11
   assign dqTermDisable   = scanMode;                                  // R11
endmodule // mbs_scan_port

// ---- rtl/mbs_pkg.sv ----
/*
   Shared constants for the memory boundary-scan port: chain length,
   forced-zero chain positions, scan-event queue sizing.
   Assumes nothing beyond a SystemVerilog-2012 compiler.
*/
package mbs_pkg;

   // Chain length in positions; bit number 1 leaves first
   localparam int CHAIN_LEN   = 67;
   // Zero-based indices of positions that always read zero
   localparam int SPARE_IDX   = 19;            // Bit number 20
   localparam int UNUSED_IDX0 = 55;            // Bit number 56
   localparam int UNUSED_IDX1 = 56;            // Bit number 57
   localparam logic [CHAIN_LEN-1:0] ONE_BIT = {{(CHAIN_LEN-1){1'b0}}, 1'b1};
   localparam logic [CHAIN_LEN-1:0] CAPTURE_MASK =
      ~((ONE_BIT << SPARE_IDX) | (ONE_BIT << UNUSED_IDX0) | (ONE_BIT << UNUSED_IDX1));
   localparam logic [CHAIN_LEN-1:0] CHAIN_RESET = '0;

   // Scan-event queue
   localparam int EVQ_WIDTH = 1;               // One bit: shift (1) or capture (0)
   localparam int EVQ_DEPTH = 16;

   // Chain engine states, one-hot
   typedef enum logic [1:0] {
      MBS_IDLE  = 2'h1,
      MBS_APPLY = 2'h2
   } mbs_state_t;

endpackage

// ---- verif/mbs_scan_port_assertions.sv ----
/*
   Checker for the memory boundary-scan port, bound to its top module.
   Assumes scan pins held steady around each scan clock pulse.
*/
module mbs_scan_port_assertions
   import mbs_pkg::*;
#(
   parameter int LEN = CHAIN_LEN
)(
   input wire logic           clk,
   input wire logic           rst,
   input wire logic           testModeSelect,
   input wire logic           scanClk,
   input wire logic           captureOrShiftSelect,
   input wire logic           resultDriveEnable,
   input wire logic           mirrorSelect,
   input wire logic           memCmdValid,
   input wire logic [LEN-1:0] padIn,
   input wire logic           serialResultOut,
   input wire logic           serialResultOe,
   input wire logic           mirrorActive,
   input wire logic           memCmdExecute,
   input wire logic           caTermNominal,
   input wire logic           dqTermDisable,
   input wire logic           scanEventReady
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Five samples leave room for the two sync flops
   sequence modeOn;  testModeSelect [*5]; endsequence
   sequence modeOff; !testModeSelect [*5]; endsequence
   sequence capEdge;
      testModeSelect && !captureOrShiftSelect && resultDriveEnable && $rose(scanClk);
   endsequence
   a_cmd_blocked: assert property (modeOn |-> !memCmdExecute)
      else $error("memory command ran in scan mode");
   a_mirror_off: assert property (modeOn |-> !mirrorActive)
      else $error("mirror active in scan mode");
   a_term_on: assert property (modeOn |-> caTermNominal && dqTermDisable)
      else $error("scan termination not set");
   a_term_off: assert property (modeOff |-> !caTermNominal && !dqTermDisable)
      else $error("scan termination outside scan mode");
   a_out_gated: assert property (!serialResultOe |-> !serialResultOut)
      else $error("result driven while undriven");
   a_oe_mode: assert property (modeOff |-> !serialResultOe)
      else $error("result enable outside scan mode");
   a_oe_cause: assert property ($rose(serialResultOe) |-> $past(resultDriveEnable, 4))
      else $error("result enable without registered enable");
   a_cap_load: assert property (capEdge |-> ##6 serialResultOut == padIn[0])
      else $error("capture did not load first pad");
endmodule // mbs_scan_port_assertions

bind mbs_scan_port mbs_scan_port_assertions #(.LEN(LEN)) chk (.*);

// ---- verif/mbs_tester.sv ----
/*
   Model of the external tester driving the scan clock and selects.
   Assumes clk is the bench clock; each pulse spans 160 ns.
*/
module mbs_tester
(
   input  wire logic clk,
   output logic      scanClk,
   output logic      shiftSel,
   output logic      driveEn
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      scanClk  = 1'b0;
      shiftSel = 1'b0;
      driveEn  = 1'b0;
   end
   // One pulse, 4 clk high and 4 clk low, so back-to-back calls give 160 ns
   // Selects move one clk before the rise and hold through it
   task automatic pulse(input logic s, input logic e);
      @(posedge clk);
      shiftSel <= s;
      driveEn  <= e;
      @(posedge clk);
      scanClk <= 1'b1;
      repeat (4) @(posedge clk);
      scanClk <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
endmodule // mbs_tester

// ---- verif/mbs_scan_port_test.sv ----
/*
   Self-checking bench of the memory boundary-scan port.
   Assumes the checker is bound and the tester model drives scan pins.
*/
module mbs_scan_port_test;
   timeunit 1ns;
   timeprecision 1ns;
   import mbs_pkg::*;
   logic                 clk, rst, testMode, mirSel, cmdValid;
   logic [CHAIN_LEN-1:0] pad;
   logic                 sClk, sel, en, serial_result_out, result_drive_enable, mirAct, cmdExec, caTerm, dqTerm, evReady;
   int                   error_cnt, samples_checked, cycles;
   logic                 expQ[$];
   event                 chk;
   mbs_tester tester (.clk(clk), .scanClk(sClk), .shiftSel(sel), .driveEn(en));
   mbs_scan_port #(.LEN(CHAIN_LEN)) DUT (.clk(clk), .rst(rst), .testModeSelect(testMode),
      .scanClk(sClk), .captureOrShiftSelect(sel), .resultDriveEnable(en),
      .mirrorSelect(mirSel), .memCmdValid(cmdValid), .padIn(pad),
      .serialResultOut(serial_result_out), .serialResultOe(result_drive_enable), .mirrorActive(mirAct),
      .memCmdExecute(cmdExec), .caTermNominal(caTerm), .dqTermDisable(dqTerm),
      .scanEventReady(evReady));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input logic seen, input logic exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t mismatch seen %b expected %b", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Note what the result pin should show once the pulse settles
   task automatic note(input logic e);
      expQ.push_back(e);
      ->chk;
   endtask
   initial
   forever
   begin
      @(chk);
      // Look away from the rising edge, where the chain may move
      @(negedge clk);
      check(serial_result_out, expQ.pop_front());
   end
   // Hang guard, well above the roughly 600 cycles needed
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         error_cnt++;
         complete_run();
      end
   end
   initial
   begin
      rst = 1'b1; testMode = 1'b0; mirSel = 1'b0; cmdValid = 1'b0; pad = '0;
      void'($urandom(71));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      cmdValid <= 1'b1;
      mirSel <= 1'b1;
      repeat (5) @(posedge clk);
      @(negedge clk);
      check(evReady, 1'b1);
      check(cmdExec, 1'b1);
      check(mirAct, 1'b1);
      check(caTerm, 1'b0);
      @(posedge clk);
      testMode <= 1'b1;
      repeat (6) @(posedge clk);
      @(negedge clk);
      check(cmdExec, 1'b0);
      check(mirAct, 1'b0);
      check(caTerm, 1'b1);
      check(dqTerm, 1'b1);
      $display("mode entry test done");
      // Forced-zero positions get ones on the pads to prove the mask
      @(posedge clk);
      pad <= CHAIN_LEN'({$urandom(), $urandom(), $urandom()}) | ~CAPTURE_MASK;
      for (int i = 0; i < 70; i++)
      begin
         tester.pulse(i != 0, 1'b1);
         note((i < 67 && i != 19 && i != 55 && i != 56) ? pad[i] : 1'b0);
      end
      @(negedge clk);
      check(result_drive_enable, 1'b1);
      $display("capture and shift test done");
      tester.pulse(1'b0, 1'b0);
      @(negedge clk);
      check(result_drive_enable, 1'b0);
      check(serial_result_out, 1'b0);
      @(posedge clk);
      testMode <= 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      check(dqTerm, 1'b0);
      check(caTerm, 1'b0);
      $display("release and exit test done");
      // Reinitialise after scan use before normal commands resume
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      check(cmdExec, 1'b1);
      check(mirAct, 1'b1);
      check(result_drive_enable, 1'b0);
      check(evReady, 1'b1);
      $display("reinit test done");
      complete_run();
   end
endmodule // mbs_scan_port_test
